// [rtl/code_reader_defs.svh]
// Purpose: offsets, field positions and reset values of the code reader capture unit
// Assumes: byte-wide register port with a two-bit address
// Notes:   definitions only
`ifndef CODE_READER_DEFS_SVH
`define CODE_READER_DEFS_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define CR_ADDR_W          2
`define CR_OFF_CNT_LO      2'h0
`define CR_OFF_CNT_HI      2'h1
`define CR_OFF_CAP_LO      2'h2
`define CR_OFF_CAP_HI      2'h3

// ----------------------------------------------------------------------
// control fields at offset 0 (write side)
// ----------------------------------------------------------------------
`define CR_MODE_LSB        0
`define CR_MODE_MSB        1
`define CR_PWR_BIT         2

// ----------------------------------------------------------------------
// widths and reset values
// ----------------------------------------------------------------------
`define CR_CNT_W           16
`define CR_DATA_W          8
`define CR_CNT_RST         16'h0000
`define CR_CAP_RST         16'h0000
`define CR_MODE_RST        2'h0
`define CR_PWR_RST         1'b0
`define CR_RDATA_RST       8'h00

`endif

// [rtl/code_reader_pkg.sv]
// Purpose: types shared by the code reader capture unit
// Assumes: nothing beyond the defs header
// Notes:   trigger mode encodings follow the two-bit control field
`default_nettype none

package code_reader_pkg;

   // ----------------------------------------------------------------------
   // trigger selection
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {
      EXTERNAL_TRIGGER_OUTPUT_OFF     = 2'h0,
      EXTERNAL_TRIGGER_OUTPUT_FALLING = 2'h1,
      EXTERNAL_TRIGGER_OUTPUT_RISING  = 2'h2,
      EXTERNAL_TRIGGER_OUTPUT_BOTH    = 2'h3
   } external_trigger_output_mode_t;

endpackage

`default_nettype wire

// [rtl/code_reader_edge_sync.sv]
// Purpose: invert, synchronise and edge-detect the reader data pin
// Assumes: pin is asynchronous to sys_clk
// Notes:   first stage feeds only the second stage
`default_nettype none

module code_reader_edge_sync
(
   input  wire logic sys_clk,
   input  wire logic rst,
   input  wire logic reader_pin,
   output logic      rise_pulse,
   output logic      fall_pulse
);

   // ----------------------------------------------------------------------
   // synchroniser and history
   // ----------------------------------------------------------------------
   logic meta_q;
   logic sync_q;
   logic last_q;

   // inverted pin through two flops, then one history flop
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         last_q <= 1'b0;
      end
      else
      begin
         meta_q <= ~reader_pin;
         sync_q <= meta_q;
         last_q <= sync_q;
      end
   end

   // single-cycle edge pulses on the inverted level
   assign rise_pulse = sync_q & ~last_q;
   assign fall_pulse = ~sync_q & last_q;

endmodule

`default_nettype wire

// [rtl/code_reader_edge_capture.sv]
// Purpose: free-running counter with edge capture for a TTL hand-held code reader
// Assumes: byte-wide processor port on sys_clk, one-cycle read and write strobes
// Notes:   capture flag doubles as the interrupt request to the processor
`default_nettype none

`include "code_reader_defs.svh"

module code_reader_edge_capture
   import code_reader_pkg::*;
#(
   parameter int CNT_W  = `CR_CNT_W,
   parameter int DATA_W = `CR_DATA_W
)
(
   input  wire logic                    sys_clk,
   input  wire logic                    rst,
   input  wire logic                    code_reader_input,
   input  wire logic                    cpu_sel,
   input  wire logic [`CR_ADDR_W-1:0]   cpu_addr,
   input  wire logic                    cpu_rd,
   input  wire logic                    cpu_wr,
   input  wire logic [DATA_W-1:0]       cpu_wdata,
   output logic      [DATA_W-1:0]       cpu_rdata,
   output logic                         capture_flag,
   output logic                         reader_power_switch
);

   // ----------------------------------------------------------------------
   // state
   // ----------------------------------------------------------------------
   logic [CNT_W-1:0]  free_running_counter_q;
   logic [CNT_W-1:0]  capture_register_q;
   external_trigger_output_mode_t        external_trigger_output_mode_q;
   logic              power_q;
   logic              flag_q;
   logic [DATA_W-1:0] rdata_q;

   // ----------------------------------------------------------------------
   // edge detection on the reader pin
   // ----------------------------------------------------------------------
   logic rise_pulse;
   logic fall_pulse;

   // inversion and synchronising happen inside
   code_reader_edge_sync u_edge
   (
      .sys_clk    (sys_clk),
      .rst        (rst),
      .reader_pin (code_reader_input),
      .rise_pulse (rise_pulse),
      .fall_pulse (fall_pulse)
   );

   // ----------------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------------
   logic wr_ctrl;
   logic wr_clear;
   logic rd_hit;
   logic trigger;

   // control write at offset 0, flag clear by any write at offset 2
   assign wr_ctrl  = cpu_sel & cpu_wr & (cpu_addr == `CR_OFF_CNT_LO);
   assign wr_clear = cpu_sel & cpu_wr & (cpu_addr == `CR_OFF_CAP_LO);
   assign rd_hit   = cpu_sel & cpu_rd;

   // trigger selection from the mode field
   assign trigger = ((external_trigger_output_mode_q == EXTERNAL_TRIGGER_OUTPUT_FALLING) & fall_pulse)
                  | ((external_trigger_output_mode_q == EXTERNAL_TRIGGER_OUTPUT_RISING)  & rise_pulse)
                  | ((external_trigger_output_mode_q == EXTERNAL_TRIGGER_OUTPUT_BOTH)
                     & (rise_pulse | fall_pulse));

   // byte select for reads
   function automatic logic [DATA_W-1:0] byte_sel
   (
      input logic [`CR_ADDR_W-1:0] a,
      input logic [CNT_W-1:0]      cnt,
      input logic [CNT_W-1:0]      cap
   );
      logic [DATA_W-1:0] r;
      r = '0;
      unique case (a)
         `CR_OFF_CNT_LO: r = cnt[DATA_W-1:0];
         `CR_OFF_CNT_HI: r = cnt[CNT_W-1:DATA_W];
         `CR_OFF_CAP_LO: r = cap[DATA_W-1:0];
         `CR_OFF_CAP_HI: r = cap[CNT_W-1:DATA_W];
      endcase
      return r;
   endfunction

   logic [DATA_W-1:0] rd_byte;
   assign rd_byte = byte_sel(cpu_addr, free_running_counter_q, capture_register_q);

   // ----------------------------------------------------------------------
   // free-running counter
   // ----------------------------------------------------------------------
   // counts every clock, wraps naturally
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         free_running_counter_q <= `CR_CNT_RST;
      else
         free_running_counter_q <= free_running_counter_q + 1'b1;
   end

   // ----------------------------------------------------------------------
   // capture register and flag
   // ----------------------------------------------------------------------
   // holds until the next trigger
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         capture_register_q <= `CR_CAP_RST;
      else if (trigger)
         capture_register_q <= free_running_counter_q;
   end

   // set wins over a clear in the same cycle
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         flag_q <= 1'b0;
      else if (trigger)
         flag_q <= 1'b1;
      else if (wr_clear)
         flag_q <= 1'b0;
   end

   // ----------------------------------------------------------------------
   // control register
   // ----------------------------------------------------------------------
   // mode field and reader power bit
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         external_trigger_output_mode_q <= EXTERNAL_TRIGGER_OUTPUT_OFF;
         power_q     <= `CR_PWR_RST;
      end
      else if (wr_ctrl)
      begin
         external_trigger_output_mode_q <= external_trigger_output_mode_t'(cpu_wdata[`CR_MODE_MSB:`CR_MODE_LSB]);
         power_q     <= cpu_wdata[`CR_PWR_BIT];
      end
   end

   // ----------------------------------------------------------------------
   // read data
   // ----------------------------------------------------------------------
   // registered, holds between reads
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         rdata_q <= `CR_RDATA_RST;
      else if (rd_hit)
         rdata_q <= rd_byte;
   end

   // outputs straight from flops
   assign cpu_rdata           = rdata_q;
   assign capture_flag        = flag_q;
   assign reader_power_switch = power_q;

endmodule

`default_nettype wire

// [verif/code_reader_edge_capture_props.sv]
// Purpose: port assertions for the edge capture unit
// Assumes: trigger mode copied from writes at offset 0
// Notes:   pin edges reach the flag within three clocks
`default_nettype none
module code_reader_edge_capture_props
   import code_reader_pkg::*;
(
   input wire logic       sys_clk,
   input wire logic       rst,
   input wire logic       code_reader_input,
   input wire logic       cpu_sel,
   input wire logic [1:0] cpu_addr,
   input wire logic       cpu_rd,
   input wire logic       cpu_wr,
   input wire logic [7:0] cpu_wdata,
   input wire logic [7:0] cpu_rdata,
   input wire logic       capture_flag,
   input wire logic       reader_power_switch
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [1:0] mode_q;
   // -----
   // decodes
   // -----
   wire logic  wr0 = cpu_sel && cpu_wr && cpu_addr == 2'h0;
   wire logic  clr = cpu_sel && cpu_wr && cpu_addr == 2'h2;
   wire logic  rd0 = cpu_sel && cpu_rd && cpu_addr == 2'h0;
   // mode copy
   always_ff @(posedge sys_clk or posedge rst)
      if (rst)
         mode_q <= 2'h0;
      else if (wr0)
         mode_q <= cpu_wdata[1:0];
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   sequence rd0_pair; rd0 ##2 rd0; endsequence
   AST_PIN_FALL: assert property (mode_q[1] && $fell(code_reader_input)
      |-> ##[1:3] capture_flag) else $error("no flag after pin fall");
   AST_PIN_RISE: assert property (mode_q[0] && $rose(code_reader_input)
      |-> ##[1:3] capture_flag) else $error("no flag after pin rise");
   AST_OFF_QUIET: assert property (mode_q == EXTERNAL_TRIGGER_OUTPUT_OFF
      |=> !$rose(capture_flag)) else $error("flag rose while off");
   AST_FLAG_HOLD: assert property (capture_flag && !clr |=> capture_flag)
      else $error("flag dropped");
   AST_FLAG_CLEAR: assert property (clr && mode_q == EXTERNAL_TRIGGER_OUTPUT_OFF |=> !capture_flag)
      else $error("flag not cleared");
   AST_RDATA_HOLD: assert property (!(cpu_sel && cpu_rd) |=> $stable(cpu_rdata))
      else $error("read data moved");
   AST_CNT_STEP: assert property (rd0_pair |=> cpu_rdata == $past(cpu_rdata) + 8'h02)
      else $error("counter step wrong");
   AST_PWR_SET: assert property (wr0 |=> reader_power_switch == $past(cpu_wdata[2]))
      else $error("power not written");
   AST_PWR_HOLD: assert property (!wr0 |=> $stable(reader_power_switch))
      else $error("power moved");
endmodule
bind code_reader_edge_capture code_reader_edge_capture_props chk (.sys_clk, .rst,
   .code_reader_input, .cpu_sel, .cpu_addr, .cpu_rd, .cpu_wr, .cpu_wdata, .cpu_rdata,
   .capture_flag, .reader_power_switch);
`default_nettype wire

// [verif/reader_model.sv]
// Purpose: hand-held reader on the data pin
// Assumes: pin high is space, low is mark
// Notes:   levels change just after a clock edge
`default_nettype none
module reader_model
(
   input  wire logic sys_clk,
   output var logic  code_reader_input
);
   timeunit 1ns;
   timeprecision 100ps;
   initial code_reader_input = 1'b1;
   // move the pin after the next edge
   task automatic drive(input logic lvl);
      @(posedge sys_clk);
      #1 code_reader_input = lvl;
   endtask
endmodule
`default_nettype wire

// [verif/code_reader_edge_capture_bench.sv]
// Purpose: self-checking bench for the edge capture unit
// Assumes: reader model on the data pin
// Notes:   mark width measured in both-edge mode
`default_nettype none
module code_reader_edge_capture_bench
   import code_reader_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic       sys_clk = 1'b0;
   logic       rst = 1'b1;
   logic       cpu_sel = 1'b0;
   logic       cpu_rd = 1'b0;
   logic       cpu_wr = 1'b0;
   logic [1:0] cpu_addr = 2'h0;
   logic [7:0] cpu_wdata = 8'h00;
   logic [7:0] cpu_rdata;
   logic       capture_flag;
   logic       reader_power_switch;
   logic       pin;
   int         failures = 0;
   int         tests_run = 0;
   always #20 sys_clk = ~sys_clk;
   reader_model rdr (.sys_clk, .code_reader_input(pin));
   code_reader_edge_capture dut (.sys_clk, .rst, .code_reader_input(pin), .cpu_sel,
      .cpu_addr, .cpu_rd, .cpu_wr, .cpu_wdata, .cpu_rdata, .capture_flag,
      .reader_power_switch);
   // -----
   // helpers
   // -----
   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      tests_run++;
      if (got !== exp)
      begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic bus(input logic w, input logic [1:0] a, input logic [7:0] d,
                      output logic [7:0] q);
      @(posedge sys_clk);
      #1 {cpu_sel, cpu_rd, cpu_wr, cpu_addr, cpu_wdata} = {1'b1, !w, w, a, d};
      @(posedge sys_clk);
      #1 {cpu_sel, cpu_rd, cpu_wr} = 3'h0;
      q = cpu_rdata;
   endtask
   task automatic rd16(input logic [1:0] a, output logic [15:0] v);
      bus(1'b0, a, 8'h00, v[7:0]);
      bus(1'b0, a + 2'h1, 8'h00, v[15:8]);
   endtask
   task automatic complete_run;
      if (failures == 0 && tests_run > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // -----
   // scenarios
   // -----
   task automatic check_reset;
      logic [15:0] v;
      rd16(2'h2, v);
      check("capture", 16'h0000, v);
      check("flag", 16'h0000, {15'h0, capture_flag});
      check("power", 16'h0000, {15'h0, reader_power_switch});
   endtask
   task automatic check_counter;
      logic [15:0] v;
      logic [15:0] w;
      bus(1'b0, 2'h0, 8'h00, v[7:0]);
      bus(1'b0, 2'h0, 8'h00, v[15:8]);
      check("counter step", 16'h0002, {8'h00, v[15:8] - v[7:0]});
      rd16(2'h0, v);
      repeat (65532) @(posedge sys_clk);
      rd16(2'h0, w);
      check("counter wrap", v, w);
   endtask
   task automatic check_modes;
      logic [15:0] lead;
      logic [15:0] trail;
      logic [7:0]  q;
      for (int m = 0; m < 4; m++)
      begin
         bus(1'b1, 2'h0, {5'h00, m[0], m[1:0]}, q);
         check("power", {15'h0, m[0]}, {15'h0, reader_power_switch});
         rdr.drive(1'b0);
         repeat (6) @(posedge sys_clk);
         check("flag on lead", {15'h0, m[1]}, {15'h0, capture_flag});
         rd16(2'h2, lead);
         bus(1'b1, 2'h2, 8'h00, q);
         check("flag cleared", 16'h0000, {15'h0, capture_flag});
         rdr.drive(1'b1);
         repeat (6) @(posedge sys_clk);
         check("flag on trail", {15'h0, m[0]}, {15'h0, capture_flag});
         rd16(2'h2, trail);
         bus(1'b1, 2'h2, 8'h00, q);
         if (m == 2)
            check("capture held", lead, trail);
         if (m == 3)
            check("mark width", 16'h000d, trail - lead);
      end
   endtask
   initial
   begin
      repeat (5) @(posedge sys_clk);
      #1 rst = 1'b0;
      check_reset;
      check_counter;
      check_modes;
      complete_run;
   end
endmodule
`default_nettype wire
